/* File: rtl/touch_status_query_consts.vh */
// Constants for the touch status query responder: command codes, fields, timing
`ifndef TOUCH_STATUS_QUERY_CONSTS_VH
`define TOUCH_STATUS_QUERY_CONSTS_VH

// Command bytes handled here
`define CMD_NULL        8'h00
`define CMD_FIRST_KEY   8'hC0
`define CMD_ALL_KEYS    8'hC1
`define CMD_STATUS      8'hC2
`define CMD_EEPROM_CRC  8'hC3
`define CMD_RAM_CRC     8'hC4
`define CMD_GROUP_ERR   8'hC5
`define CMD_DIAG        8'hC6
`define CMD_LAST_CMD    8'hC7
`define CMD_DUMP        8'hC8

// Device status bit positions
`define ST_DETECT       7
`define ST_EEPROM_ERR   6
`define ST_RESET_OCC    5
`define ST_EXTREME      4
`define ST_SYNC_ERR     3
`define ST_EEPROM_CRC   2
`define ST_RAM_CRC      1
`define ST_CAL_ERR      0

// Expected first byte of a valid EEPROM image
`define EEPROM_MARKER   8'hD6
// Response CRC: reflected polynomial and seed
`define CRC_POLY        8'h8C
`define CRC_INIT        8'h00
// Setup block length in bytes
`define SETUP_LEN       8'h64
`define SETUP_LAST      8'h63

// Timing: clock rate and one-second intervals
`define CLK_MHZ             125
`define CRC_CHECK_MS        1000
`define SYNC_TIMEOUT_MS     1000
`define CRC_CHECK_CYCLES    (`CRC_CHECK_MS * 1000 * `CLK_MHZ)
`define SYNC_TIMEOUT_CYCLES (`SYNC_TIMEOUT_MS * 1000 * `CLK_MHZ)

`endif

/* File: rtl/resp_crc8.v */
// One byte step of the response CRC
`timescale 1ns/1ps
`include "touch_status_query_consts.vh"

module resp_crc8 (
    // Running value and new byte
    input  wire [7:0] crc_in,
    input  wire [7:0] data_in,
    // Updated value
    output reg  [7:0] crc_out
);

    integer i;  // Bit loop index

    // Bitwise shift of the reflected polynomial, LSB first
    always @* begin
        crc_out = crc_in ^ data_in;
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_out[0]) begin
                crc_out = (crc_out >> 1) ^ `CRC_POLY;
            end else begin
                crc_out = crc_out >> 1;
            end
        end
    end

endmodule // resp_crc8

/* File: rtl/touch_status_query_responder.v */
// Query command responder: key reports, status flags, CRC replies and setup dump
`timescale 1ns/1ps
`include "touch_status_query_consts.vh"

module touch_status_query_responder #(
    parameter [31:0] CRC_CHECK_CYCLES    = `CRC_CHECK_CYCLES,
    parameter [31:0] SYNC_TIMEOUT_CYCLES = `SYNC_TIMEOUT_CYCLES
) (
    // Clock and reset
    input  wire       clk,
    input  wire       reset,
    // Command bytes from the serial port
    input  wire       cmd_valid,
    input  wire [7:0] cmd_byte,
    // Reply bytes to the serial port
    output reg        resp_valid,
    output reg  [7:0] resp_byte,
    input  wire       resp_ready,
    // Acquisition engine per-key state
    input  wire [9:0] key_detect,
    input  wire [9:0] key_cal_err_set,
    input  wire [9:0] key_extreme_set,
    input  wire [9:0] key_recal_ok,
    // EEPROM checks
    input  wire       eeprom_detect_pin,
    input  wire [7:0] eeprom_first_byte,
    input  wire       eeprom_setup_crc_ok,
    input  wire [7:0] eeprom_crc_now,
    input  wire [7:0] eeprom_crc_ref,
    // RAM setup block checks
    input  wire [7:0] ram_crc_now,
    input  wire [7:0] ram_crc_ref,
    // Setup block read port, data valid for the current address
    output reg  [7:0] setup_addr,
    input  wire [7:0] setup_data,
    // Misc inputs
    input  wire       sync_pulse,
    input  wire [7:0] diag_code,
    input  wire       error_key_mode,
    input  wire       standalone_mode,
    // Status outputs
    output reg        major_error,
    output reg  [9:0] key_disable,
    output reg  [7:0] device_status
);

    // Reply engine states
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_DATA  = 3'h1;
    localparam [2:0] S_CRC   = 3'h2;
    localparam [2:0] S_DLOAD = 3'h3;
    localparam [2:0] S_DSEND = 3'h4;

    // Per-key sticky flags
    reg  [9:0]  cal_err_reg;        // Calibration error per key
    reg  [9:0]  ext_err_reg;        // Extreme signal per key
    // Sticky device flags
    reg         eep_err_reg;        // EEPROM missing or bad
    reg         reset_occ_reg;      // Reset seen since last clear
    reg         sync_err_reg;       // Sync pulses missed
    reg         eep_crc_err_reg;    // Periodic EEPROM CRC mismatch
    reg         ram_crc_err_reg;    // Periodic RAM CRC mismatch
    // Timers
    reg  [31:0] sec_cnt_reg;        // One-second check divider
    reg  [31:0] sync_cnt_reg;       // Cycles since last sync pulse
    // Key tracking
    reg  [3:0]  first_key_reg;      // Key that entered detection first
    // Command history
    reg  [7:0]  last_cmd_reg;       // Previous non-null command
    reg         prev_status_reg;    // Previous command was a status query
    // Reply engine
    reg  [2:0]  state_reg;
    reg  [7:0]  second_reg;         // Pending second data byte
    reg         has_second_reg;     // Second data byte still to send
    reg         crc_on_reg;         // Append CRC after data
    reg  [7:0]  crc_reg;            // Running reply CRC

    // Combinational helpers
    reg  [1:0]  count_next;         // Saturated key count
    reg  [3:0]  lowest_key;         // Lowest index in detection
    reg  [7:0]  status_next;        // Live status byte
    reg         any_error;          // OR of every error
    integer     k;
    wire [7:0]  crc_seed;           // CRC after the command byte
    wire [7:0]  crc_step;           // CRC after the byte being sent
    wire        take_cmd;           // Non-null command arrives
    wire        accepted;           // Reply byte taken
    wire        clear_sticky;       // Status query followed by echo
    wire        sec_tick;           // One-second check point
    wire        eep_absent;         // No EEPROM fitted
    wire [9:0]  group_err;          // Per-key error map

    assign take_cmd     = cmd_valid && (cmd_byte != `CMD_NULL);
    assign accepted     = resp_valid && resp_ready;
    assign clear_sticky = take_cmd && (cmd_byte == `CMD_LAST_CMD) && prev_status_reg;
    assign sec_tick     = (sec_cnt_reg == CRC_CHECK_CYCLES - 32'h1);
    assign eep_absent   = eeprom_detect_pin;
    assign group_err    = cal_err_reg | ext_err_reg;

    // CRC seeded with the command itself
    resp_crc8 u_crc_seed (
        .crc_in  (`CRC_INIT),
        .data_in (cmd_byte),
        .crc_out (crc_seed)
    );

    // CRC advanced by the byte now on the reply port
    resp_crc8 u_crc_step (
        .crc_in  (crc_reg),
        .data_in (resp_byte),
        .crc_out (crc_step)
    );

    // Key count, lowest detected key and the live status byte
    always @* begin
        count_next = 2'h0;
        lowest_key = 4'h0;
        for (k = 9; k >= 0; k = k - 1) begin
            if (key_detect[k]) begin
                lowest_key = k[3:0];
            end
        end
        for (k = 0; k < 10; k = k + 1) begin
            if (key_detect[k] && count_next != 2'h3) begin
                count_next = count_next + 2'h1;
            end
        end
        status_next                 = 8'h00;
        status_next[`ST_DETECT]     = |key_detect;
        status_next[`ST_EEPROM_ERR] = eep_err_reg;
        status_next[`ST_RESET_OCC]  = reset_occ_reg;
        status_next[`ST_EXTREME]    = |ext_err_reg;
        status_next[`ST_SYNC_ERR]   = sync_err_reg;
        status_next[`ST_EEPROM_CRC] = eep_crc_err_reg;
        status_next[`ST_RAM_CRC]    = ram_crc_err_reg;
        status_next[`ST_CAL_ERR]    = |cal_err_reg;
        any_error = |status_next[6:0];
    end

    // Per-key flags: a new error wins over a recalibration in the same cycle
    always @(posedge clk) begin
        if (reset) begin
            cal_err_reg <= 10'h000;
            ext_err_reg <= 10'h000;
        end else begin
            cal_err_reg <= key_cal_err_set | (cal_err_reg & ~key_recal_ok);
            ext_err_reg <= key_extreme_set | (ext_err_reg & ~key_recal_ok);
        end
    end

    // One-second divider for the periodic CRC checks
    always @(posedge clk) begin
        if (reset || sec_tick) begin
            sec_cnt_reg <= 32'h0;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h1;
        end
    end

    // Sync watchdog; saturates so a long gap does not wrap and re-arm
    always @(posedge clk) begin
        if (reset || sync_pulse) begin
            sync_cnt_reg <= 32'h0;
        end else if (sync_cnt_reg != SYNC_TIMEOUT_CYCLES) begin
            sync_cnt_reg <= sync_cnt_reg + 32'h1;
        end
    end

    // Sticky device flags; any set term beats the status-then-echo clear
    always @(posedge clk) begin
        if (reset) begin
            eep_err_reg     <= 1'b0;
            reset_occ_reg   <= 1'b1;  // A reset is itself the event
            sync_err_reg    <= 1'b0;
            eep_crc_err_reg <= 1'b0;
            ram_crc_err_reg <= 1'b0;
        end else begin
            if (eep_absent || eeprom_first_byte != `EEPROM_MARKER || !eeprom_setup_crc_ok) begin
                eep_err_reg <= 1'b1;
            end else if (clear_sticky) begin
                eep_err_reg <= 1'b0;
            end
            if (clear_sticky) begin
                reset_occ_reg <= 1'b0;
            end
            if (sync_cnt_reg == SYNC_TIMEOUT_CYCLES - 32'h1) begin
                sync_err_reg <= 1'b1;
            end else if (clear_sticky) begin
                sync_err_reg <= 1'b0;
            end
            if (sec_tick && !eep_absent && eeprom_crc_now != eeprom_crc_ref) begin
                eep_crc_err_reg <= 1'b1;
            end else if (clear_sticky) begin
                eep_crc_err_reg <= 1'b0;
            end
            if (sec_tick && ram_crc_now != ram_crc_ref) begin
                ram_crc_err_reg <= 1'b1;
            end else if (clear_sticky) begin
                ram_crc_err_reg <= 1'b0;
            end
        end
    end

    // First key: keep the holder while it stays in detection, else take the lowest
    always @(posedge clk) begin
        if (reset) begin
            first_key_reg <= 4'h0;
        end else if (!key_detect[first_key_reg] || first_key_reg > 4'h9) begin
            first_key_reg <= lowest_key;
        end
    end

    // Command history for the echo query and the flag clear
    always @(posedge clk) begin
        if (reset) begin
            last_cmd_reg    <= 8'h00;
            prev_status_reg <= 1'b0;
        end else if (take_cmd) begin
            last_cmd_reg    <= cmd_byte;
            prev_status_reg <= (cmd_byte == `CMD_STATUS);
        end
    end

    // Registered status outputs; major errors force output only in error-key mode
    always @(posedge clk) begin
        if (reset) begin
            major_error   <= 1'b0;
            key_disable   <= 10'h000;
            device_status <= 8'h00;
        end else begin
            major_error <= error_key_mode &&
                           ((status_next[`ST_EXTREME] && !standalone_mode) ||
                            eep_crc_err_reg || ram_crc_err_reg ||
                            status_next[`ST_CAL_ERR]);
            key_disable   <= ext_err_reg | cal_err_reg;
            device_status <= status_next;
        end
    end

    // Reply engine; commands that arrive mid-reply are logged but not answered
    always @(posedge clk) begin
        if (reset) begin
            state_reg      <= S_IDLE;
            resp_valid     <= 1'b0;
            resp_byte      <= 8'h00;
            second_reg     <= 8'h00;
            has_second_reg <= 1'b0;
            crc_on_reg     <= 1'b0;
            crc_reg        <= `CRC_INIT;
            setup_addr     <= 8'h00;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (take_cmd) begin
                        crc_reg        <= crc_seed;
                        crc_on_reg     <= 1'b1;
                        has_second_reg <= 1'b0;
                        resp_valid     <= 1'b1;
                        state_reg      <= S_DATA;
                        case (cmd_byte)
                            `CMD_FIRST_KEY: begin
                                // Bit 6 is reserved and always sent as zero
                                resp_byte <= {any_error, 1'b0, count_next,
                                              (|key_detect) ? first_key_reg : 4'h0};
                            end
                            `CMD_ALL_KEYS: begin
                                resp_byte      <= {6'h00, key_detect[9:8]};
                                second_reg     <= key_detect[7:0];
                                has_second_reg <= 1'b1;
                            end
                            `CMD_STATUS: begin
                                resp_byte <= status_next;
                            end
                            `CMD_EEPROM_CRC: begin
                                resp_byte <= eep_absent ? 8'h00 : eeprom_crc_now;
                            end
                            `CMD_RAM_CRC: begin
                                resp_byte <= ram_crc_now;
                            end
                            `CMD_GROUP_ERR: begin
                                resp_byte      <= {6'h00, group_err[9:8]};
                                second_reg     <= group_err[7:0];
                                has_second_reg <= 1'b1;
                            end
                            `CMD_DIAG: begin
                                resp_byte <= diag_code;
                            end
                            `CMD_LAST_CMD: begin
                                resp_byte  <= ~last_cmd_reg;
                                crc_on_reg <= 1'b0;
                            end
                            `CMD_DUMP: begin
                                // Dump CRC covers setup data only
                                crc_reg    <= `CRC_INIT;
                                setup_addr <= 8'h00;
                                resp_valid <= 1'b0;
                                state_reg  <= S_DLOAD;
                            end
                            default: begin
                                // Not a query handled here: stay silent
                                resp_valid <= 1'b0;
                                state_reg  <= S_IDLE;
                            end
                        endcase
                    end
                end
                S_DATA: begin
                    if (accepted) begin
                        crc_reg <= crc_step;
                        if (has_second_reg) begin
                            resp_byte      <= second_reg;
                            has_second_reg <= 1'b0;
                        end else if (crc_on_reg) begin
                            resp_byte <= crc_step;
                            state_reg <= S_CRC;
                        end else begin
                            resp_valid <= 1'b0;
                            state_reg  <= S_IDLE;
                        end
                    end
                end
                S_CRC: begin
                    if (accepted) begin
                        resp_valid <= 1'b0;
                        state_reg  <= S_IDLE;
                    end
                end
                S_DLOAD: begin
                    // Setup byte for the current address is on setup_data
                    resp_byte  <= setup_data;
                    resp_valid <= 1'b1;
                    state_reg  <= S_DSEND;
                end
                S_DSEND: begin
                    if (accepted) begin
                        crc_reg <= crc_step;
                        if (setup_addr == `SETUP_LAST) begin
                            resp_byte <= crc_step;
                            state_reg <= S_CRC;
                        end else begin
                            setup_addr <= setup_addr + 8'h01;
                            resp_valid <= 1'b0;
                            state_reg  <= S_DLOAD;
                        end
                    end
                end
                default: begin
                    resp_valid <= 1'b0;
                    state_reg  <= S_IDLE;
                end
            endcase
        end
    end

endmodule // touch_status_query_responder

/* File: sim/touch_status_query_checker.sv */
// Port-level assertions for the query responder
`timescale 1ns/1ps
`include "touch_status_query_consts.vh"
module touch_status_query_checker (
    // Clock and reset
    input wire       clk,
    input wire       reset,
    // Command and reply
    input wire       cmd_valid,
    input wire [7:0] cmd_byte,
    input wire       resp_valid,
    input wire [7:0] resp_byte,
    input wire       resp_ready,
    input wire [7:0] setup_addr,
    // Key events and mode
    input wire [9:0] key_detect,
    input wire [9:0] key_cal_err_set,
    input wire [9:0] key_extreme_set,
    input wire       error_key_mode,
    // Status
    input wire       major_error,
    input wire [7:0] device_status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_query_answered: assert property (
        cmd_valid && cmd_byte >= `CMD_FIRST_KEY && cmd_byte <= `CMD_LAST_CMD && !resp_valid |=> resp_valid)
        else $error("query got no reply");
    a_reply_held: assert property (
        resp_valid && !resp_ready |=> resp_valid && $stable(resp_byte))
        else $error("reply byte dropped before taken");
    a_unknown_silent: assert property (
        cmd_valid && cmd_byte < `CMD_FIRST_KEY && !resp_valid |=> !resp_valid)
        else $error("reply to null or unknown byte");
    a_dump_start: assert property (
        cmd_valid && cmd_byte == `CMD_DUMP && !resp_valid |=> setup_addr == 8'h00 ##1 resp_valid)
        else $error("dump did not start at address zero");
    a_detect_flag: assert property (
        $stable(key_detect) [*4] |-> device_status[7] == (|key_detect))
        else $error("detect flag wrong");
    a_extreme_sets: assert property (
        |key_extreme_set |-> ##[1:3] device_status[4])
        else $error("extreme flag not set");
    a_cal_sets: assert property (
        |key_cal_err_set |-> ##[1:3] device_status[0])
        else $error("cal flag not set");
    a_major_gated: assert property (
        !error_key_mode |=> !major_error)
        else $error("major error outside error-key mode");
    a_sticky_hold: assert property (
        !cmd_valid && !$past(cmd_valid) && !$past(cmd_valid, 2)
        |=> (device_status & $past(device_status) & 8'h6E) == ($past(device_status) & 8'h6E))
        else $error("sticky flag lost without clear");
    a_reset_seen: assert property (
        $fell(reset) |-> ##[0:2] device_status[5])
        else $error("reset flag missing");
    c_dump: cover property (cmd_valid && cmd_byte == `CMD_DUMP);
    c_stall: cover property (resp_valid && !resp_ready);
    c_major: cover property (major_error);
endmodule // touch_status_query_checker

bind touch_status_query_responder touch_status_query_checker chk (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .resp_valid(resp_valid), .resp_byte(resp_byte), .resp_ready(resp_ready),
    .setup_addr(setup_addr), .key_detect(key_detect), .key_cal_err_set(key_cal_err_set),
    .key_extreme_set(key_extreme_set), .error_key_mode(error_key_mode),
    .major_error(major_error), .device_status(device_status));

/* File: sim/host_query_model.sv */
// Host model: sends query bytes, takes reply bytes with optional stalls
`timescale 1ns/1ps
module host_query_model (
    // Clock
    input  wire       clk,
    // Command side
    output reg        cmd_valid = 1'b0,
    output reg  [7:0] cmd_byte = 8'h00,
    // Reply side
    input  wire       resp_valid,
    input  wire [7:0] resp_byte,
    output reg        resp_ready = 1'b1
);
    integer   seed = 35004; // Shared random seed
    reg       slow = 1'b0;  // Stall replies at random
    reg [7:0] rx[$];        // Bytes taken
    integer   lost = 0;     // Replies that never completed
    // One strobed command, then collect n reply bytes under a bound
    task query(input [7:0] c, input integer n);
        integer i;
        begin
            rx.delete();
            @(posedge clk);
            #1 cmd_valid = 1'b1;
            cmd_byte = c;
            @(posedge clk);
            #1 cmd_valid = 1'b0;
            cmd_byte = ~c; // Idle bus never shows the last byte
            for (i = 0; i < 2000 && rx.size() < n; i = i + 1) begin
                @(posedge clk);
                if (resp_valid && resp_ready) rx.push_back(resp_byte);
                #1 resp_ready = !slow || ($random(seed) % 2 != 0);
            end
            if (rx.size() < n) lost = lost + 1;
        end
    endtask
endmodule // host_query_model

/* File: sim/test_touch_status_query_responder.sv */
// Self-checking bench for the touch status query responder
`timescale 1ns/1ps
`include "touch_status_query_consts.vh"
module test_touch_status_query_responder;
    reg        clk = 1'b0;        // 125 MHz
    reg        reset = 1'b1;      // Synchronous, active high
    wire       cmd_valid;         // Host side
    wire [7:0] cmd_byte;
    wire       resp_valid;
    wire [7:0] resp_byte;
    wire       resp_ready;
    wire [7:0] setup_addr;        // Setup read port
    wire       major_error;       // Status outputs
    wire [9:0] key_disable;
    wire [7:0] device_status;
    reg  [9:0] key_detect = 10'h000;
    reg  [9:0] cal_set = 10'h000; // Per-key pulses
    reg  [9:0] ext_set = 10'h000;
    reg  [9:0] recal = 10'h000;
    reg        no_ee = 1'b0;      // High: no EEPROM
    reg  [7:0] ee_now = 8'h3C;    // Live CRCs, equal to refs
    reg  [7:0] ram_now = 8'h5A;
    reg  [7:0] diag = 8'h00;
    reg        ek_mode = 1'b0;
    reg        alone = 1'b0;      // Standalone mode
    reg        sync_pulse = 1'b0;
    reg        sync_on = 1'b1;    // Clear to starve sync
    reg  [9:0] ext = 10'h000;     // Model per-key flags
    reg  [9:0] cal = 10'h000;
    reg  [7:0] sticky = 8'h00;    // Model sticky bits
    reg  [7:0] last = 8'h00;      // Model last command
    reg  [7:0] eq[$];             // Expected reply
    integer    fails = 0;
    integer    cmp_count = 0;
    integer    k;
    always #4 clk = ~clk;
    // Sync pulses well inside the shortened timeout
    always begin
        repeat (20) @(posedge clk);
        #1 sync_pulse = sync_on;
        @(posedge clk);
        #1 sync_pulse = 1'b0;
    end
    host_query_model h (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .resp_valid(resp_valid), .resp_byte(resp_byte), .resp_ready(resp_ready));
    touch_status_query_responder #(.CRC_CHECK_CYCLES(64), .SYNC_TIMEOUT_CYCLES(50)) DUT (
        .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .resp_valid(resp_valid), .resp_byte(resp_byte), .resp_ready(resp_ready),
        .key_detect(key_detect), .key_cal_err_set(cal_set), .key_extreme_set(ext_set),
        .key_recal_ok(recal), .eeprom_detect_pin(no_ee), .eeprom_first_byte(`EEPROM_MARKER),
        .eeprom_setup_crc_ok(1'b1), .eeprom_crc_now(ee_now), .eeprom_crc_ref(8'h3C),
        .ram_crc_now(ram_now), .ram_crc_ref(8'h5A), .setup_addr(setup_addr),
        .setup_data(setup_addr ^ 8'hA5), .sync_pulse(sync_pulse), .diag_code(diag),
        .error_key_mode(ek_mode), .standalone_mode(alone), .major_error(major_error),
        .key_disable(key_disable), .device_status(device_status));
    // Bitwise reflected CRC step
    function [7:0] crc8(input [7:0] c, input [7:0] b);
        integer i;
        begin
            crc8 = c ^ b;
            for (i = 0; i < 8; i = i + 1)
                crc8 = crc8[0] ? (crc8 >> 1) ^ `CRC_POLY : crc8 >> 1;
        end
    endfunction
    // Expected live status byte
    function [7:0] xs();
        xs = sticky | {|key_detect, 2'b00, |ext, 3'b000, |cal};
    endfunction
    // Expected first-key report; lowest key wins when several rise together
    function [7:0] rep();
        integer i, n;
        reg [3:0] f;
        begin
            n = 0;
            f = 4'h0;
            for (i = 9; i >= 0; i = i - 1)
                if (key_detect[i]) begin
                    n = n + 1;
                    f = i[3:0];
                end
            rep = {(xs() & 8'h7F) != 8'h00, 1'b0, (n > 3) ? 2'd3 : n[1:0], f};
        end
    endfunction
    task chk(input [15:0] g, input [15:0] e);
        begin
            cmp_count = cmp_count + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("BAD %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    task wrap_up();
        begin
            $display("Compares %0d, mismatches %0d", cmp_count, fails);
            if (fails == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // Query with n data bytes; md 0 no CRC, 1 command folded, 2 data only
    task go(input [7:0] c, input [15:0] v, input integer n, input integer md, input [7:0] m0);
        reg [7:0] cr;
        integer i;
        begin
            if (n == 2) eq.push_back(v[15:8]);
            if (n > 0) eq.push_back(v[7:0]);
            cr = (md == 1) ? crc8(`CRC_INIT, c) : `CRC_INIT;
            for (i = 0; i < eq.size(); i = i + 1)
                cr = crc8(cr, eq[i]);
            if (md != 0) eq.push_back(cr);
            h.query(c, eq.size());
            if (h.lost != 0) begin
                fails = fails + 1;
                wrap_up();
            end
            // Bit 6 of the first-key byte is masked like a host would
            for (i = 0; i < eq.size(); i = i + 1)
                chk(h.rx[i] & ((i == 0) ? m0 : 8'hFF), eq[i] & ((i == 0) ? m0 : 8'hFF));
            eq.delete();
            last = c;
        end
    endtask
    // Status then echo, with a null between, clears the sticky bits
    task clr();
        begin
            go(`CMD_STATUS, xs(), 1, 1, 8'hFF);
            h.query(`CMD_NULL, 0);
            go(`CMD_LAST_CMD, ~last, 1, 0, 8'hFF);
            sticky = 8'h00;
        end
    endtask
    task done(input string s);
        $display("Test %s done", s);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        sticky = 8'h20;
        go(`CMD_FIRST_KEY, rep(), 1, 1, 8'hBF);
        clr();
        go(`CMD_STATUS, xs(), 1, 1, 8'hFF);
        done("reset flags");
        for (k = 0; k < 12; k = k + 1) begin
            h.slow = k[0];
            key_detect = 10'h000;
            tick(3);
            key_detect = (k == 0) ? 10'h200 : (k == 1) ? 10'h000 : (k == 2) ? 10'h3FF : 10'($random(h.seed));
            tick(3);
            go(`CMD_FIRST_KEY, rep(), 1, 1, 8'hBF);
            go(`CMD_ALL_KEYS, key_detect, 2, 1, 8'hFF);
        end
        done("key reports");
        ext_set = 10'h008;
        alone = 1'b1;
        tick(1);
        ext_set = 10'h000;
        ext = 10'h008;
        tick(2);
        chk(major_error, 0);
        ek_mode = 1'b1;
        tick(2);
        chk(major_error, 0);
        alone = 1'b0;
        cal_set = 10'h080;
        tick(1);
        cal_set = 10'h000;
        cal = 10'h080;
        tick(2);
        chk(major_error, 1);
        chk(key_disable, 10'h088);
        go(`CMD_STATUS, xs(), 1, 1, 8'hFF);
        go(`CMD_GROUP_ERR, ext | cal, 2, 1, 8'hFF);
        recal = 10'h088;
        tick(1);
        recal = 10'h000;
        ext = 10'h000;
        cal = 10'h000;
        tick(3);
        go(`CMD_STATUS, xs(), 1, 1, 8'hFF);
        go(`CMD_GROUP_ERR, 0, 2, 1, 8'hFF);
        chk(major_error, 0);
        done("key errors");
        sync_on = 1'b0;
        tick(70);
        sync_on = 1'b1;
        tick(30);
        sticky = 8'h08;
        go(`CMD_STATUS, xs(), 1, 1, 8'hFF);
        clr();
        ee_now = 8'h77;
        ram_now = 8'h11;
        tick(140);
        go(`CMD_EEPROM_CRC, ee_now, 1, 1, 8'hFF);
        go(`CMD_RAM_CRC, ram_now, 1, 1, 8'hFF);
        ee_now = 8'h3C;
        ram_now = 8'h5A;
        tick(140);
        sticky = 8'h06;
        go(`CMD_FIRST_KEY, rep(), 1, 1, 8'hBF);
        chk(major_error, 1);
        clr();
        no_ee = 1'b1;
        tick(3);
        go(`CMD_EEPROM_CRC, 0, 1, 1, 8'hFF);
        sticky = 8'h40;
        go(`CMD_STATUS, xs(), 1, 1, 8'hFF);
        no_ee = 1'b0;
        clr();
        go(`CMD_STATUS, xs(), 1, 1, 8'hFF);
        done("error flags");
        diag = 8'($random(h.seed));
        go(`CMD_DIAG, diag, 1, 1, 8'hFF);
        h.query(8'h5C, 0);
        last = 8'h5C;
        repeat (2) go(`CMD_LAST_CMD, ~last, 1, 0, 8'hFF);
        h.slow = 1'b1;
        for (k = 0; k < `SETUP_LEN; k = k + 1)
            eq.push_back(8'(k) ^ 8'hA5);
        go(`CMD_DUMP, 0, 0, 2, 8'hFF);
        done("codes and dump");
        wrap_up();
    end
endmodule // test_touch_status_query_responder
